// ---- logic/ocpm_top.sv ----
// module: oscillator enables, system clock switching and halt power modes
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module ocpm_top
    import ocpm_pkg::*;
#(
    parameter int unsigned SETTLE = SETTLE_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DW-1:0] rdata,
    input wire ocpm_scc_t system_clock_control_reg,
    input wire logic halt,
    input wire logic wake,
    input wire logic wdt_enabled,
    input wire logic crystal_pins_en,
    input wire logic hs_from_crystal,
    input wire ocpm_ready_t ready_pin,
    output logic fast_int_on,
    output logic fast_xtal_on,
    output logic slow_xtal_on,
    output logic [4:0] fast_int_mhz,
    output logic crystal_drive_mode,
    output logic slow_crystal_speedup,
    output logic sys_clk_en,
    output logic sys_is_slow,
    output logic fast_clk_run,
    output logic sub_clk_run,
    output logic hold_state,
    output logic wdt_run,
    output ocpm_wdt_evt_t wdt_evt,
    output ocpm_pmode_t pmode
);
    if (SUB_DIV > (1 << SUB_W) || SUB_DIV < 2) begin : g_chk
        $error("ocpm_top: subsystem divider does not fit");
    end

    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(SUB_DIV - 1);

    function automatic logic [4:0] freq_mhz(input logic [1:0] code);
        case (code)
            2'h1: freq_mhz = MHZ_12;
            2'h2: freq_mhz = MHZ_16;
            default: freq_mhz = MHZ_8;
        endcase
    endfunction

    function automatic logic [5:0] div_mask(input logic [2:0] cks);
        div_mask = 6'((7'h01 << cks) - 7'h01);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    ocpm_ready_t rdy_s1_q;
    ocpm_ready_t rdy_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdy_s1_q <= '0;
            rdy_q <= '0;
        end else begin
            rdy_s1_q <= ready_pin;
            rdy_q <= rdy_s1_q;
        end
    end

    // ------------------------------------------------------------
    // oscillator control registers
    // ------------------------------------------------------------
    logic fhi_en_q;
    logic [1:0] fsel_q;
    logic fxt_en_q;
    logic drive_q;
    logic sxt_en_q;
    logic speedup_q;
    logic wr_fhi;
    logic wr_fxt;
    logic wr_sxt;
    logic fsel_restart;
    logic drive_lock;
    logic speedup_lock;

    assign wr_fhi = wr && addr == ADDR_FHI;
    assign wr_fxt = wr && addr == ADDR_FXT;
    assign wr_sxt = wr && addr == ADDR_SXT;
    assign fsel_restart = wr_fhi && wdata[FSEL_HI:FSEL_LO] != fsel_q;
    assign drive_lock = crystal_pins_en && fxt_en_q;
    assign speedup_lock = system_clock_control_reg.cks == CKS_SLOW && system_clock_control_reg.slow_source_select == FSS_CRYSTAL;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fhi_en_q <= FHI_EN_RST;
            fsel_q <= FSEL_RST;
        end else if (wr_fhi) begin
            fhi_en_q <= wdata[BIT_EN];
            fsel_q <= wdata[FSEL_HI:FSEL_LO];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fxt_en_q <= FXT_EN_RST;
            drive_q <= DRIVE_RST;
        end else if (wr_fxt) begin
            fxt_en_q <= wdata[BIT_EN];
            if (!drive_lock) begin
                drive_q <= wdata[BIT_MODE];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sxt_en_q <= SXT_EN_RST;
            speedup_q <= SPEEDUP_RST;
        end else if (wr_sxt) begin
            sxt_en_q <= wdata[BIT_EN];
            if (!speedup_lock) begin
                speedup_q <= wdata[BIT_MODE];
            end
        end
    end

    // ------------------------------------------------------------
    // stable flags
    // ------------------------------------------------------------
    logic fhi_stable;
    logic fxt_stable;
    logic sxt_stable;

    // a stopped fast clock also stops the oscillators behind it
    ocpm_osc_stab #(.SETTLE(SETTLE)) u_fhi (
        .clk(clk),
        .nrst(nrst),
        .en(fhi_en_q && fast_clk_run),
        .restart(fsel_restart),
        .ready(rdy_q.fast_int),
        .stable_q(fhi_stable)
    );

    ocpm_osc_stab #(.SETTLE(SETTLE)) u_fxt (
        .clk(clk),
        .nrst(nrst),
        .en(fxt_en_q && fast_clk_run),
        .restart(1'b0),
        .ready(rdy_q.fast_xtal),
        .stable_q(fxt_stable)
    );

    ocpm_osc_stab #(.SETTLE(SETTLE)) u_sxt (
        .clk(clk),
        .nrst(nrst),
        .en(sxt_en_q && sub_clk_run),
        .restart(1'b0),
        .ready(rdy_q.slow_xtal),
        .stable_q(sxt_stable)
    );

    // frequency moves only once the flag is high again
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fast_int_mhz <= MHZ_8;
        end else if (fhi_stable) begin
            fast_int_mhz <= freq_mhz(fsel_q);
        end
    end

    // ------------------------------------------------------------
    // system clock dividers and switching
    // ------------------------------------------------------------
    ocpm_sw_t sw_q;
    ocpm_pmode_t pm_q;
    logic [2:0] cks_act_q;
    logic fss_act_q;
    logic [2:0] sw_cnt_q;
    logic [5:0] div_q;
    logic [SUB_W-1:0] sub_q;
    logic fast_tick;
    logic sub_src_ok;
    logic sub_tick;
    logic cur_tick;
    logic req;
    logic tgt_stable;
    logic apply;

    assign fast_tick = div_q == div_mask(cks_act_q);
    assign sub_src_ok = fss_act_q == FSS_CRYSTAL ? sxt_stable : rdy_q.slow_int;
    assign sub_tick = sub_clk_run && sub_src_ok && sub_q == SUB_LAST;
    assign cur_tick = sys_is_slow ? sub_tick : fast_tick;
    assign req = system_clock_control_reg.cks != cks_act_q || (system_clock_control_reg.cks == CKS_SLOW && system_clock_control_reg.slow_source_select != fss_act_q);
    assign apply = sw_q == SW_WAIT && req && tgt_stable;

    always_comb begin
        if (system_clock_control_reg.cks == CKS_SLOW) begin
            tgt_stable = system_clock_control_reg.slow_source_select == FSS_CRYSTAL ? sxt_stable : rdy_q.slow_int;
        end else begin
            tgt_stable = hs_from_crystal ? fxt_stable : fhi_stable;
        end
    end

    // the fast divider restarts at a switch, so the first fast period of the new
    // setting is whole; the sub divider runs on, so a first slow period can be short
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
        end else if (apply || fast_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sub_q <= '0;
        end else if (!sub_clk_run || !sub_src_ok || sub_q == SUB_LAST) begin
            sub_q <= '0;
        end else begin
            sub_q <= sub_q + 1'b1;
        end
    end

    // four current periods are counted before the target is taken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw_q <= SW_IDLE;
            sw_cnt_q <= '0;
        end else begin
            case (sw_q)
                SW_IDLE: begin
                    sw_cnt_q <= '0;
                    if (req && pm_q == PM_RUN) begin
                        sw_q <= SW_COUNT;
                    end
                end
                SW_COUNT: begin
                    if (sw_cnt_q == SWITCH_PERIODS) begin
                        sw_q <= SW_WAIT;
                    end else if (cur_tick && pm_q == PM_RUN) begin
                        sw_cnt_q <= sw_cnt_q + 1'b1;
                    end
                end
                SW_WAIT: begin
                    if (!req || apply) begin
                        sw_q <= SW_IDLE;
                    end
                end
                default: sw_q <= SW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cks_act_q <= CKS_RST;
            fss_act_q <= 1'b0;
            sys_is_slow <= 1'b0;
        end else if (apply) begin
            cks_act_q <= system_clock_control_reg.cks;
            fss_act_q <= system_clock_control_reg.slow_source_select;
            sys_is_slow <= system_clock_control_reg.cks == CKS_SLOW;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sys_clk_en <= 1'b0;
        end else begin
            sys_clk_en <= pm_q == PM_RUN && cur_tick;
        end
    end

    // ------------------------------------------------------------
    // halt power modes
    // ------------------------------------------------------------
    // select and idle bits are taken in the halt cycle itself
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pm_q <= PM_RUN;
        end else begin
            case (pm_q)
                PM_RUN: begin
                    if (halt) begin
                        case ({system_clock_control_reg.fast_idle_enable, system_clock_control_reg.sub_idle_enable})
                            2'h0: pm_q <= PM_SLEEP;
                            2'h1: pm_q <= PM_IDLE_SUB_ONLY_MODE;
                            2'h3: pm_q <= PM_IDLE_BOTH_CLOCKS_MODE;
                            default: pm_q <= PM_IDLE_FAST_ONLY_MODE;
                        endcase
                    end
                end
                PM_SLEEP, PM_IDLE_SUB_ONLY_MODE, PM_IDLE_BOTH_CLOCKS_MODE, PM_IDLE_FAST_ONLY_MODE: begin
                    if (wake) begin
                        pm_q <= PM_RUN;
                    end
                end
                default: pm_q <= PM_RUN;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wdt_evt <= '0;
        end else begin
            wdt_evt.pdf_set <= pm_q == PM_RUN && halt;
            wdt_evt.timeout_clr <= pm_q == PM_RUN && halt;
            wdt_evt.wdt_clear <= pm_q == PM_RUN && halt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fast_clk_run <= 1'b1;
            sub_clk_run <= 1'b1;
            hold_state <= 1'b0;
            wdt_run <= 1'b0;
            pmode <= PM_RUN;
        end else begin
            fast_clk_run <= pm_q inside {PM_RUN, PM_IDLE_BOTH_CLOCKS_MODE, PM_IDLE_FAST_ONLY_MODE};
            sub_clk_run <= pm_q inside {PM_RUN, PM_IDLE_SUB_ONLY_MODE, PM_IDLE_BOTH_CLOCKS_MODE};
            hold_state <= pm_q != PM_RUN;
            wdt_run <= wdt_enabled;
            pmode <= pm_q;
        end
    end

    // oscillator power follows enable bits and the clocks still running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fast_int_on <= 1'b0;
            fast_xtal_on <= 1'b0;
            slow_xtal_on <= 1'b0;
            crystal_drive_mode <= DRIVE_RST;
            slow_crystal_speedup <= SPEEDUP_RST;
        end else begin
            fast_int_on <= fhi_en_q && fast_clk_run;
            fast_xtal_on <= fxt_en_q && fast_clk_run;
            slow_xtal_on <= sxt_en_q && sub_clk_run;
            crystal_drive_mode <= drive_q;
            slow_crystal_speedup <= speedup_q;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                ADDR_FHI: rdata <= {4'h0, fsel_q, fhi_stable, fhi_en_q};
                ADDR_FXT: rdata <= {5'h00, drive_q, fxt_stable, fxt_en_q};
                ADDR_SXT: rdata <= {5'h00, speedup_q, sxt_stable, sxt_en_q};
                ADDR_STAT: rdata <= {3'h0, sw_q != SW_IDLE, sys_is_slow, cks_act_q};
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_FREQ_MAP: assert property (
        @(posedge clk) disable iff (!nrst)
        fhi_stable |=> fast_int_mhz == freq_mhz($past(fsel_q)))
        else $error("applied frequency does not match code");

    AST_FREQ_HOLD: assert property (
        @(posedge clk) disable iff (!nrst)
        !fhi_stable |=> $stable(fast_int_mhz))
        else $error("frequency changed before stable");

    AST_FHI_RESTART: assert property (
        @(posedge clk) disable iff (!nrst)
        fsel_restart |=> !fhi_stable [*2])
        else $error("stable flag not cleared on code change");

    AST_DRIVE_LOCK: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_fxt && drive_lock |=> $stable(drive_q))
        else $error("drive mode changed while locked");

    AST_SPEEDUP_LOCK: assert property (
        @(posedge clk) disable iff (!nrst)
        wr_sxt && speedup_lock |=> $stable(speedup_q))
        else $error("speed-up changed while slow crystal selected");

    AST_SLOW_SOURCE: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(sys_is_slow) |-> $past(tgt_stable))
        else $error("slow switch without stable source");

    AST_SWITCH_DELAY: assert property (
        @(posedge clk) disable iff (!nrst)
        $changed(cks_act_q) |-> $past(sw_q == SW_WAIT && sw_cnt_q == SWITCH_PERIODS))
        else $error("switch taken before four periods");

    AST_SLEEP_ENTRY: assert property (
        @(posedge clk) disable iff (!nrst)
        pm_q == PM_RUN && halt && !system_clock_control_reg.fast_idle_enable && !system_clock_control_reg.sub_idle_enable
        |=> pm_q == PM_SLEEP ##1 (!sys_clk_en && !fast_clk_run && !sub_clk_run) [*3])
        else $error("sleep entry wrong");

    AST_IDLE_SUB_ONLY_MODE_ENTRY: assert property (
        @(posedge clk) disable iff (!nrst)
        pm_q == PM_RUN && halt && !system_clock_control_reg.fast_idle_enable && system_clock_control_reg.sub_idle_enable
        |=> pm_q == PM_IDLE_SUB_ONLY_MODE ##1 (!fast_clk_run && sub_clk_run && hold_state))
        else $error("idle_sub_only_mode entry wrong");

    AST_HALT_FLAGS: assert property (
        @(posedge clk) disable iff (!nrst)
        pm_q == PM_RUN && halt |=> wdt_evt == '1 ##1 wdt_evt == '0)
        else $error("halt flag pulses wrong");
endmodule

// ---- logic/ocpm_pkg.sv ----
// package: constants and carriers of the oscillator and power mode control
package ocpm_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SUB_HZ = 32_768;
    localparam int unsigned SUB_DIV = CLK_HZ / SUB_HZ;
    localparam int unsigned SUB_W = 10;
    localparam int unsigned SETTLE_CYC = 16;
    localparam int AW = 4;
    localparam int DW = 8;
    // register offsets
    localparam logic [AW-1:0] ADDR_FHI = 4'h0;
    localparam logic [AW-1:0] ADDR_FXT = 4'h1;
    localparam logic [AW-1:0] ADDR_SXT = 4'h2;
    localparam logic [AW-1:0] ADDR_STAT = 4'h3;
    // field positions; enable and stable bits shared by the three oscillator registers
    localparam int BIT_EN = 0;
    localparam int BIT_STABLE = 1;
    localparam int BIT_MODE = 2;
    localparam int FSEL_LO = 2;
    localparam int FSEL_HI = 3;
    localparam int STAT_SLOW = 3;
    localparam int STAT_BUSY = 4;
    // reset values
    localparam logic FHI_EN_RST = 1'b1;
    localparam logic [1:0] FSEL_RST = 2'h0;
    localparam logic FXT_EN_RST = 1'b0;
    localparam logic DRIVE_RST = 1'b0;
    localparam logic SXT_EN_RST = 1'b0;
    localparam logic SPEEDUP_RST = 1'b0;
    localparam logic [2:0] CKS_RST = 3'h0;
    // clock selection
    localparam logic [2:0] CKS_SLOW = 3'h7;
    localparam logic FSS_CRYSTAL = 1'b1;
    localparam logic [2:0] SWITCH_PERIODS = 3'h4;
    // applied fast internal frequency in MHz
    localparam logic [4:0] MHZ_8 = 5'h08;
    localparam logic [4:0] MHZ_12 = 5'h0c;
    localparam logic [4:0] MHZ_16 = 5'h10;

    typedef enum logic [4:0] {
        PM_RUN = 5'b00001,
        PM_SLEEP = 5'b00010,
        PM_IDLE_SUB_ONLY_MODE = 5'b00100,
        PM_IDLE_BOTH_CLOCKS_MODE = 5'b01000,
        PM_IDLE_FAST_ONLY_MODE = 5'b10000
    } ocpm_pmode_t;

    typedef enum logic [2:0] {
        SW_IDLE = 3'b001,
        SW_COUNT = 3'b010,
        SW_WAIT = 3'b100
    } ocpm_sw_t;

    typedef struct packed {
        logic fast_int;
        logic fast_xtal;
        logic slow_xtal;
        logic slow_int;
    } ocpm_ready_t;

    typedef struct packed {
        logic [2:0] cks;
        logic slow_source_select;
        logic fast_idle_enable;
        logic sub_idle_enable;
    } ocpm_scc_t;

    typedef struct packed {
        logic pdf_set;
        logic timeout_clr;
        logic wdt_clear;
    } ocpm_wdt_evt_t;
endpackage

// ---- logic/ocpm_osc_stab.sv ----
// module: stable flag tracker of one oscillator
`timescale 1ns/1ps
module ocpm_osc_stab
    import ocpm_pkg::*;
#(
    parameter int unsigned SETTLE = SETTLE_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic restart,
    input wire logic ready,
    output logic stable_q
);
    localparam int CW = $clog2(SETTLE + 1);
    localparam logic [CW-1:0] LOAD = CW'(SETTLE);

    if (SETTLE < 1) begin : g_chk
        $error("ocpm_osc_stab: SETTLE must be at least 1");
    end

    logic [CW-1:0] cnt_q;

    // the flag drops first and rises only after the oscillator has been
    // ready for a full settle time; a restart wins over a pending set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= LOAD;
            stable_q <= 1'b0;
        end else if (!en || restart) begin
            cnt_q <= LOAD;
            stable_q <= 1'b0;
        end else if (!ready) begin
            cnt_q <= LOAD;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end else begin
            stable_q <= 1'b1;
        end
    end
endmodule

// ---- test/ocpm_core_model.sv ----
// partner model: cpu core halt and wake pulses, oscillator ready lines
`timescale 1ns/1ps
module ocpm_core_model
    import ocpm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic fast_int_on,
    input wire logic fast_xtal_on,
    input wire logic slow_xtal_on,
    output logic halt,
    output logic wake,
    output ocpm_ready_t ready_pin
);
    logic [2:0] fi_q;
    logic [2:0] fx_q;
    logic [2:0] sx_q;

    initial begin
        halt = 1'b0;
        wake = 1'b0;
    end

    // ----------------------------------------
    // oscillators
    // ----------------------------------------
    // ready lags power by three cycles, so a stable flag can never be early
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fi_q <= 3'h0;
            fx_q <= 3'h0;
            sx_q <= 3'h0;
        end else begin
            fi_q <= {fi_q[1:0], fast_int_on};
            fx_q <= {fx_q[1:0], fast_xtal_on};
            sx_q <= {sx_q[1:0], slow_xtal_on};
        end
    end
    // slow internal runs free for the watchdog
    assign ready_pin = {fi_q[2], fx_q[2], sx_q[2], 1'b1};

    // ----------------------------------------
    // core
    // ----------------------------------------
    // one-cycle halt or wake, as the core executes it
    task automatic pulse_core(input logic is_wake);
        @(posedge clk);
        if (is_wake) wake <= 1'b1;
        else halt <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        halt <= 1'b0;
    endtask
endmodule

// ---- test/ocpm_top_bench.sv ----
// testbench: registers, clock switching and halt power modes
`timescale 1ns/1ps
module ocpm_top_bench
    import ocpm_pkg::*;
;
    localparam int unsigned ST = 2;
    localparam int WAIT_ST = 20;
    logic clk = 1'b0;
    logic nrst, wr, rd, halt, wake, wdt_enabled, crystal_pins_en, hs_from_crystal;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata;
    ocpm_scc_t system_clock_control_reg;
    ocpm_ready_t ready_pin;
    logic fast_int_on, fast_xtal_on, slow_xtal_on, crystal_drive_mode, slow_crystal_speedup;
    logic sys_clk_en, sys_is_slow, fast_clk_run, sub_clk_run, hold_state, wdt_run;
    logic [4:0] fast_int_mhz;
    ocpm_wdt_evt_t wdt_evt;
    ocpm_pmode_t pmode;
    logic [DW-1:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [1:0] code;
    int errors, samples_checked, seed, n;

    ocpm_top #(.SETTLE(ST)) u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .system_clock_control_reg(system_clock_control_reg), .halt(halt), .wake(wake),
        .wdt_enabled(wdt_enabled), .crystal_pins_en(crystal_pins_en),
        .hs_from_crystal(hs_from_crystal),
        .ready_pin(ready_pin), .fast_int_on(fast_int_on), .fast_xtal_on(fast_xtal_on),
        .slow_xtal_on(slow_xtal_on), .fast_int_mhz(fast_int_mhz),
        .crystal_drive_mode(crystal_drive_mode), .slow_crystal_speedup(slow_crystal_speedup),
        .sys_clk_en(sys_clk_en), .sys_is_slow(sys_is_slow), .fast_clk_run(fast_clk_run),
        .sub_clk_run(sub_clk_run), .hold_state(hold_state), .wdt_run(wdt_run),
        .wdt_evt(wdt_evt), .pmode(pmode));
    ocpm_core_model u_core (.clk(clk), .nrst(nrst), .fast_int_on(fast_int_on),
        .fast_xtal_on(fast_xtal_on), .slow_xtal_on(slow_xtal_on), .halt(halt), .wake(wake),
        .ready_pin(ready_pin));

    always #20 clk = ~clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic wait_slow(input logic want, input int limit);
        n = 0;
        while (sys_is_slow !== want && n < limit) begin
            @(posedge clk);
            n++;
        end
        check("sys_is_slow", {7'h0, want}, {7'h0, sys_is_slow});
    endtask
    function automatic logic [4:0] fmhz(input logic [1:0] c);
        return (c == 2'h1) ? MHZ_12 : (c == 2'h2) ? MHZ_16 : MHZ_8;
    endfunction

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen === 1'b1) check("rdata", exp_q.pop_front(), rdata);
        rd_seen <= rd;
    end

    initial begin
        #(40 * 20000);
        errors++;
        give_verdict();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {nrst, wr, rd, wdt_enabled, crystal_pins_en, hs_from_crystal} = 6'h00;
        addr = '0;
        wdata = '0;
        system_clock_control_reg = '0;
        seed = 32'h3db5;
        errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(ADDR_FHI, 8'h01);
        rd_reg(ADDR_FXT, 8'h00);
        rd_reg(ADDR_SXT, 8'h00);
        rd_reg(4'hf, 8'h00);
        repeat (WAIT_ST) @(posedge clk);
        rd_reg(ADDR_FHI, 8'h03);
        // ends on code 0, matching the configured 8 MHz
        for (int i = 1; i <= 4; i++) begin
            code = i[1:0];
            wr_reg(ADDR_FHI, {4'($random(seed)), code, 1'($random(seed)), 1'b1});
            @(posedge clk);
            rd_reg(ADDR_FHI, {4'h0, code, 2'h1});
            check("mhz_old", {3'h0, fmhz(code - 2'h1)}, {3'h0, fast_int_mhz});
            repeat (WAIT_ST) @(posedge clk);
            rd_reg(ADDR_FHI, {4'h0, code, 2'h3});
            check("mhz_new", {3'h0, fmhz(code)}, {3'h0, fast_int_mhz});
        end
        wr_reg(ADDR_FXT, 8'h04);
        rd_reg(ADDR_FXT, 8'h04);
        check("drive", 8'h01, {7'h0, crystal_drive_mode});
        crystal_pins_en <= 1'b1;
        wr_reg(ADDR_FXT, 8'h05);
        wr_reg(ADDR_FXT, 8'h01);
        rd_reg(ADDR_FXT, 8'h05);
        repeat (WAIT_ST) @(posedge clk);
        rd_reg(ADDR_FXT, 8'h07);
        check("fast_xtal_on", 8'h01, {7'h0, fast_xtal_on});
        crystal_pins_en <= 1'b0;
        wr_reg(ADDR_FXT, 8'h01);
        rd_reg(ADDR_FXT, 8'h03);
        wr_reg(ADDR_SXT, 8'h05);
        rd_reg(ADDR_SXT, 8'h05);
        repeat (WAIT_ST) @(posedge clk);
        rd_reg(ADDR_SXT, 8'h07);
        check("speedup", 8'h01, {7'h0, slow_crystal_speedup});
        system_clock_control_reg.cks <= CKS_SLOW;
        system_clock_control_reg.slow_source_select <= FSS_CRYSTAL;
        wait_slow(1'b1, 100);
        check("to_slow_min", 8'h01, {7'h0, n >= 4});
        wr_reg(ADDR_SXT, 8'h01);
        rd_reg(ADDR_SXT, 8'h07);
        rd_reg(ADDR_STAT, 8'h0f);
        // slow source moves to the internal oscillator, which unlocks the speed-up bit
        system_clock_control_reg.slow_source_select <= 1'b0;
        repeat (5 * SUB_DIV) @(posedge clk);
        rd_reg(ADDR_STAT, 8'h0f);
        wr_reg(ADDR_SXT, 8'h01);
        rd_reg(ADDR_SXT, 8'h03);
        system_clock_control_reg.cks <= 3'h2;
        hs_from_crystal <= 1'b1;
        wait_slow(1'b0, 5000);
        check("to_fast_min", 8'h01, {7'h0, n >= 3 * SUB_DIV});
        rd_reg(ADDR_STAT, 8'h02);
        n = 0;
        repeat (64) begin
            @(posedge clk);
            #1;
            if (sys_clk_en === 1'b1) n++;
        end
        check("sys_clk_en_count", 8'h10, n[7:0]);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            system_clock_control_reg.fast_idle_enable <= m[1];
            system_clock_control_reg.sub_idle_enable <= m[0];
            wdt_enabled <= 1'($random(seed));
            u_core.pulse_core(1'b0);
            #1;
            check("wdt_evt", 8'h07, {5'h0, wdt_evt});
            @(posedge clk);
            #1;
            check("pmode", (m == 0) ? 8'h02 : (m == 1) ? 8'h04 : (m == 2) ? 8'h10 : 8'h08,
                {3'h0, pmode});
            check("clk_run", m[1:0], {6'h0, fast_clk_run, sub_clk_run});
            check("hold_wdt", {6'h0, 1'b1, wdt_enabled}, {6'h0, hold_state, wdt_run});
            u_core.pulse_core(1'b0);
            #1;
            check("halt_refused", 8'h00, {5'h0, wdt_evt});
            check("sys_clk_en_off", 8'h00, {7'h0, sys_clk_en});
            check("osc_on", {6'h0, m[1], m[0]}, {6'h0, fast_int_on, slow_xtal_on});
            u_core.pulse_core(1'b1);
            repeat (3) @(posedge clk);
            #1;
            check("pmode_run", 8'h01, {3'h0, pmode});
        end
        give_verdict();
    end
endmodule
